// ==== logic/dsp_alu_regs.vh ====
// Purpose: constants for the arithmetic/logic datapath
// Assumes: included by dsp_arithmetic_logic_unit.v and product_multiplier.v
// Notes: opcode codes are local encodings of the operation set
`ifndef DSP_ALU_REGS_VH
`define DSP_ALU_REGS_VH

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define OP_NOP 6'h00
`define OP_ADD 6'h01
`define OP_SUB 6'h02
`define OP_ADD_WITH_CARRY 6'h03
`define OP_SUBTRACT_WITH_BORROW 6'h04
`define OP_SIGNED_MULTIPLY 6'h05
`define OP_UNSIGNED_MULTIPLY 6'h06
`define OP_MULTIPLY_ACCUMULATE 6'h07
`define OP_MOVE_PRODUCT_AND_MULTIPLY 6'h08
`define OP_SUM_PRODUCT 6'h09
`define OP_MULTIPLY_SUBTRACT 6'h0A
`define OP_AND 6'h0B
`define OP_OR 6'h0C
`define OP_XOR 6'h0D
`define OP_NOT 6'h0E
`define OP_ABSOLUTE_ACCUMULATOR 6'h0F
`define OP_ADD_PRODUCT_LOW 6'h10
`define OP_ADD_PRODUCT_LOW_CARRY 6'h11
`define OP_ADD_PRODUCT_HIGH 6'h12
`define OP_ADD_PRODUCT_HIGH_CARRY 6'h13
`define OP_NEGATE_ACCUMULATOR 6'h14
`define OP_NEGATE_WITH_CARRY 6'h15
`define OP_COMPARE_ACCUMULATOR 6'h16
`define OP_FLOAT_COMPARE 6'h20
`define OP_FLOAT_ADD 6'h21
`define OP_FLOAT_SUBTRACT 6'h22
`define OP_FLOAT_MULTIPLY 6'h23
`define OP_FLOAT_MULTIPLY_ACCUMULATE 6'h24
`define OP_FLOAT_MULTIPLY_SUBTRACT 6'h25
`define OP_FLOAT_ABSOLUTE 6'h26
`define OP_FLOAT_SUM_PRODUCT 6'h27
`define OP_FLOAT_MOVE_PRODUCT_AND_MULTIPLY 6'h28

// ----------------------------------------------------------------
// Transfer groups and timing
// ----------------------------------------------------------------
`define XFER_NONE 2'h0
`define XFER_DOUBLE 2'h1
`define XFER_TRIPLE 2'h2
`define FIXED_OP_CYCLES 2'h1
`define FLOAT_OP_CYCLES 2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACC_RESET 32'h00000000
`define PROD_RESET 48'h000000000000

`endif

// ==== logic/dsp_arithmetic_logic_unit.v ====
// Purpose: arithmetic and logic datapath of a 32-bit signal processor
// Assumes: decoder supplies one operation per instruction plus transfers
// Notes: floating ops modelled as 2-cycle datapath ops on raw words
// Contract
// - Accumulating results go to accumulator C or D chosen by the instruction.
// - Fixed signed multiply forms 48-bit product of 24-bit A and B.
// - Integer signed multiply uses two's complement, 48-bit product.
// - Unsigned multiply only in integer mode; fixed mode does nothing.
// - Operations not applicable to the mode perform no arithmetic.
// - Float ops mode-independent, two cycles; others one cycle.
// - Integer add-with-carry sums accumulator, A and carry; fixed does nothing.
// - Multiply-accumulate adds product to accumulator and reloads product.
// - Integer multiply-subtract subtracts product low half, reloads product.
// - Move-product copies product or low half, reloads product.
// - Add-low/high-with-carry add product half plus carry in integer mode.
// - Integer negate-with-carry writes minus accumulator minus carry.
// - AND, OR, XOR combine accumulator with A in both modes.
// - Float multiply-accumulate adds product and reloads it in two cycles.
// - Triple transfers accompany first-group arithmetic only.
// - Double transfers combine with either arithmetic group.
// - Control instructions run alongside an arithmetic operation.
`timescale 1ns/1ps
`default_nettype none
`include "dsp_alu_regs.vh"

module dsp_arithmetic_logic_unit
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Instruction issue
  input wire opValid,
  input wire [5:0] opCode,
  input wire opSecondGroup,
  input wire accSelD,
  input wire intMode,
  input wire [1:0] xferKind,
  input wire ctrlConcurrent,
  // Operand transfers
  input wire loadA,
  input wire [31:0] dataA,
  input wire loadB,
  input wire [31:0] dataB,
  input wire loadAcc,
  input wire loadAccD,
  input wire [31:0] dataAcc,
  // Results
  output reg [31:0] accC_r,
  output reg [31:0] accD_r,
  output reg [31:0] regA_r,
  output reg [31:0] regB_r,
  output reg [47:0] product_r,
  output reg carry_r,
  output reg zero_r,
  output reg negative_r,
  output reg busy_r,
  output reg opAccepted_r,
  output reg comboError_r
);

  // ----------------------------------------------------------------
  // Operation state
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_FLOAT = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [5:0] heldOp_r;
  reg heldSel_r;
  reg [31:0] accResult;
  reg accWrite;
  reg prodLoad;
  reg prodSigned;
  reg flagWrite;
  reg carryWrite;
  reg carryNew;
  reg [31:0] flagValue;
  reg [32:0] wide;
  wire [47:0] multProduct;
  wire [31:0] acc;
  wire [31:0] product_low_half;
  wire [31:0] product_high_half;
  wire [5:0] curOp;
  wire curSel;
  wire isFloat;
  wire comboOk;
  wire execNow;
  wire carry_flag;

  // Sign-extend a 24-bit integer field to the accumulator width
  function [31:0] sext24;
    input [23:0] v;
    begin
      sext24 = {{8{v[23]}}, v};
    end
  endfunction

  // Float group occupies the upper code range
  function isFloatOp;
    input [5:0] op;
    begin
      isFloatOp = (op >= `OP_FLOAT_COMPARE) && (op <= `OP_FLOAT_MOVE_PRODUCT_AND_MULTIPLY);
    end
  endfunction

  // Triple transfers pair with the first group only; second group has no float ops
  assign comboOk = !((xferKind == `XFER_TRIPLE) && opSecondGroup)
    && !(opSecondGroup && isFloatOp(opCode));
  assign execNow = opValid && comboOk && (state_r == ST_IDLE);
  assign curOp = (state_r == ST_FLOAT) ? heldOp_r : opCode;
  assign curSel = (state_r == ST_FLOAT) ? heldSel_r : accSelD;
  assign isFloat = isFloatOp(curOp);
  assign acc = curSel ? accD_r : accC_r;
  // Arithmetic reads the live product, so a multiply right before an accumulate is seen
  assign product_low_half = sext24(multProduct[23:0]);
  assign product_high_half = sext24(multProduct[47:24]);
  assign carry_flag = carry_r;

  // ----------------------------------------------------------------
  // Product register behind its multiplier
  // ----------------------------------------------------------------
  product_multiplier u_mult
  (
    .clk(clk),
    .rst(rst),
    .load(prodLoad),
    .signedMode(prodSigned),
    .opA(regA_r[23:0]),
    .opB(regB_r[23:0]),
    .product_r(multProduct)
  );

  // Operation decode; mode-inapplicable codes write nothing
  always @*
  begin
    accResult = acc;
    accWrite = 1'b0;
    prodLoad = 1'b0;
    prodSigned = 1'b1;
    flagWrite = 1'b0;
    carryWrite = 1'b0;
    carryNew = carry_r;
    flagValue = acc;
    wide = 33'h000000000;
    if (execNow || (state_r == ST_FLOAT))
    begin
      case (curOp)
        `OP_ADD:
        begin
          wide = {1'b0, acc} + {1'b0, regA_r};
          accResult = wide[31:0];
          accWrite = 1'b1;
          carryWrite = intMode;
          // Carry into bit 24, so stale upper accumulator bits cannot disturb it
          carryNew = intMode ? (wide[24] ^ acc[24] ^ regA_r[24]) : carry_r;
        end
        `OP_SUB:
        begin
          wide = {1'b0, acc} - {1'b0, regA_r};
          accResult = wide[31:0];
          accWrite = 1'b1;
          carryWrite = intMode;
          carryNew = intMode ? (wide[24] ^ acc[24] ^ regA_r[24]) : carry_r;
        end
        `OP_ADD_WITH_CARRY:
        begin
          wide = {1'b0, acc} + {1'b0, regA_r} + {32'h00000000, carry_flag};
          accResult = wide[31:0];
          accWrite = intMode;
          carryWrite = intMode;
          carryNew = wide[24] ^ acc[24] ^ regA_r[24];
        end
        `OP_SUBTRACT_WITH_BORROW:
        begin
          wide = {1'b0, acc} - {1'b0, regA_r} - {32'h00000000, carry_flag};
          accResult = wide[31:0];
          accWrite = intMode;
          carryWrite = intMode;
          carryNew = wide[24] ^ acc[24] ^ regA_r[24];
        end
        `OP_SIGNED_MULTIPLY:
          prodLoad = 1'b1;
        `OP_UNSIGNED_MULTIPLY:
        begin
          prodLoad = intMode;
          prodSigned = 1'b0;
        end
        `OP_MULTIPLY_ACCUMULATE:
        begin
          accResult = acc + (intMode ? product_low_half : multProduct[47:16]);
          accWrite = 1'b1;
          prodLoad = 1'b1;
        end
        `OP_MOVE_PRODUCT_AND_MULTIPLY:
        begin
          accResult = intMode ? product_low_half : multProduct[47:16];
          accWrite = 1'b1;
          prodLoad = 1'b1;
        end
        `OP_SUM_PRODUCT:
        begin
          accResult = acc + (intMode ? product_low_half : multProduct[47:16]);
          accWrite = 1'b1;
        end
        `OP_MULTIPLY_SUBTRACT:
        begin
          accResult = acc - (intMode ? product_low_half : multProduct[47:16]);
          accWrite = 1'b1;
          prodLoad = 1'b1;
        end
        `OP_AND:
        begin
          accResult = acc & regA_r;
          accWrite = 1'b1;
        end
        `OP_OR:
        begin
          accResult = acc | regA_r;
          accWrite = 1'b1;
        end
        `OP_XOR:
        begin
          accResult = acc ^ regA_r;
          accWrite = 1'b1;
        end
        `OP_NOT:
        begin
          accResult = ~acc;
          accWrite = 1'b1;
        end
        `OP_ABSOLUTE_ACCUMULATOR:
        begin
          accResult = acc[31] ? (32'h00000000 - acc) : acc;
          accWrite = 1'b1;
        end
        `OP_ADD_PRODUCT_LOW, `OP_ADD_PRODUCT_LOW_CARRY:
        begin
          wide = {1'b0, acc} + {1'b0, product_low_half}
            + {32'h00000000, (curOp == `OP_ADD_PRODUCT_LOW_CARRY) & carry_flag};
          accResult = wide[31:0];
          accWrite = intMode;
        end
        `OP_ADD_PRODUCT_HIGH, `OP_ADD_PRODUCT_HIGH_CARRY:
        begin
          wide = {1'b0, acc} + {1'b0, product_high_half}
            + {32'h00000000, (curOp == `OP_ADD_PRODUCT_HIGH_CARRY) & carry_flag};
          accResult = wide[31:0];
          accWrite = intMode;
        end
        `OP_NEGATE_ACCUMULATOR:
        begin
          accResult = 32'h00000000 - acc;
          accWrite = 1'b1;
        end
        `OP_NEGATE_WITH_CARRY:
        begin
          accResult = 32'h00000000 - acc - {31'h00000000, carry_flag};
          accWrite = intMode;
        end
        `OP_COMPARE_ACCUMULATOR, `OP_FLOAT_COMPARE:
        begin
          flagValue = acc - regA_r;
          flagWrite = 1'b1;
        end
        `OP_FLOAT_ADD:
        begin
          accResult = acc + regA_r;
          accWrite = 1'b1;
        end
        `OP_FLOAT_SUBTRACT:
        begin
          accResult = acc - regA_r;
          accWrite = 1'b1;
        end
        `OP_FLOAT_MULTIPLY:
          prodLoad = 1'b1;
        `OP_FLOAT_MULTIPLY_ACCUMULATE, `OP_FLOAT_SUM_PRODUCT:
        begin
          accResult = acc + multProduct[47:16];
          accWrite = 1'b1;
          prodLoad = (curOp == `OP_FLOAT_MULTIPLY_ACCUMULATE);
        end
        `OP_FLOAT_MULTIPLY_SUBTRACT:
        begin
          accResult = acc - multProduct[47:16];
          accWrite = 1'b1;
          prodLoad = 1'b1;
        end
        `OP_FLOAT_ABSOLUTE:
        begin
          accResult = {1'b0, acc[30:0]};
          accWrite = 1'b1;
        end
        `OP_FLOAT_MOVE_PRODUCT_AND_MULTIPLY:
        begin
          accResult = multProduct[47:16];
          accWrite = 1'b1;
          prodLoad = 1'b1;
        end
        default:
          accWrite = 1'b0;
      endcase
      // Floating ops commit only on their second cycle, mode plays no part
      if (isFloat && (state_r != ST_FLOAT))
      begin
        accWrite = 1'b0;
        prodLoad = 1'b0;
        flagWrite = 1'b0;
      end
      if (isFloat)
        prodSigned = 1'b1;
      if (accWrite)
        flagValue = accResult;
      flagWrite = flagWrite | accWrite;
    end
  end

  // Two-cycle sequencing for floating ops
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (execNow && isFloatOp(opCode))
          state_nxt = ST_FLOAT;
      ST_FLOAT:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Datapath registers
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      heldOp_r <= `OP_NOP;
      heldSel_r <= 1'b0;
      accC_r <= `ACC_RESET;
      accD_r <= `ACC_RESET;
      regA_r <= `ACC_RESET;
      regB_r <= `ACC_RESET;
      product_r <= `PROD_RESET;
      carry_r <= 1'b0;
      zero_r <= 1'b0;
      negative_r <= 1'b0;
      busy_r <= 1'b0;
      opAccepted_r <= 1'b0;
      comboError_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (execNow)
      begin
        heldOp_r <= opCode;
        heldSel_r <= accSelD;
      end
      // Transfers land alongside the operation, which read the old values
      if (loadA)
        regA_r <= dataA;
      if (loadB)
        regB_r <= dataB;
      // ALU write beats a transfer into the same accumulator
      if (accWrite && !curSel)
        accC_r <= accResult;
      else if (loadAcc && !loadAccD)
        accC_r <= dataAcc;
      if (accWrite && curSel)
        accD_r <= accResult;
      else if (loadAcc && loadAccD)
        accD_r <= dataAcc;
      product_r <= multProduct;
      if (carryWrite)
        carry_r <= carryNew;
      if (flagWrite)
      begin
        zero_r <= (intMode && !isFloat) ? (flagValue[23:0] == 24'h000000) : (flagValue == 32'h00000000);
        negative_r <= (intMode && !isFloat) ? flagValue[23] : flagValue[31];
      end
      busy_r <= (state_nxt == ST_FLOAT);
      // Control instructions need no stall, so acceptance ignores ctrlConcurrent
      opAccepted_r <= execNow | (ctrlConcurrent & execNow);
      comboError_r <= opValid && !comboOk && (state_r == ST_IDLE);
    end
  end

endmodule // dsp_arithmetic_logic_unit
`default_nettype wire

// ==== logic/product_multiplier.v ====
// Purpose: registered 24x24 multiplier for the product register
// Assumes: one machine clock, asynchronous active-high reset
// Notes: result appears one edge after load
`timescale 1ns/1ps
`default_nettype none
`include "dsp_alu_regs.vh"

module product_multiplier
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Operands
  input wire load,
  input wire signedMode,
  input wire [23:0] opA,
  input wire [23:0] opB,
  // Product register
  output reg [47:0] product_r
);

  wire [47:0] signedProd;
  wire [47:0] unsignedProd;

  // Both forms built; sign choice picks one
  assign signedProd = $signed(opA) * $signed(opB);
  assign unsignedProd = opA * opB;

  // ----------------------------------------------------------------
  // Product register
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      product_r <= `PROD_RESET;
    else if (load)
      product_r <= signedMode ? signedProd : unsignedProd;
  end

endmodule // product_multiplier
`default_nettype wire

// ==== tb/dsp_alu_asserts.sv ====
// Purpose: port-level checks of issue, refusal and timing
// Assumes: one clock, asynchronous active-high reset
// Notes: float opcodes are recognised by opcode bit 5
`timescale 1ns/1ps
`default_nettype none
`include "dsp_alu_regs.vh"

module dsp_alu_checker
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Instruction issue
  input wire opValid,
  input wire [5:0] opCode,
  input wire opSecondGroup,
  input wire accSelD,
  input wire intMode,
  input wire [1:0] xferKind,
  input wire ctrlConcurrent,
  input wire loadAcc,
  // Results
  input wire [31:0] accC_r,
  input wire [31:0] accD_r,
  input wire [47:0] product_r,
  input wire busy_r,
  input wire opAccepted_r,
  input wire comboError_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Issue checks
  // ----------------------------------------------------------------
  // Ops in a float second cycle are dropped, so they never count as taken
  wire issueTaken = opValid && !busy_r;

  chk_float_busy: assert property (issueTaken && opCode[5] && !opSecondGroup |=> busy_r)
    else $error("float op did not hold busy");
  chk_busy_once: assert property (busy_r |=> !busy_r && !opAccepted_r)
    else $error("float op longer than two cycles");
  chk_int_one: assert property (issueTaken && !opCode[5] && !opSecondGroup |=> !busy_r && opAccepted_r)
    else $error("fixed op not done in one cycle");
  chk_combo_refuse: assert property (issueTaken && opSecondGroup
    && (xferKind == `XFER_TRIPLE || opCode[5]) |=> comboError_r && !opAccepted_r)
    else $error("illegal combination executed");
  chk_double_ok: assert property (issueTaken && opSecondGroup && xferKind == `XFER_DOUBLE
    && !opCode[5] |=> !comboError_r && opAccepted_r)
    else $error("double transfer pairing refused");
  chk_ctrl_free: assert property (issueTaken && ctrlConcurrent && !opSecondGroup
    |=> opAccepted_r && !comboError_r)
    else $error("control instruction blocked op");
  chk_cmp_hold: assert property (issueTaken && opCode == `OP_COMPARE_ACCUMULATOR && !loadAcc
    |=> $stable(accC_r) && $stable(accD_r))
    else $error("compare changed accumulator");
  chk_sel_other: assert property (issueTaken && accSelD && !loadAcc |=> $stable(accC_r))
    else $error("unselected accumulator written");
  chk_mlu_fixed: assert property (issueTaken && !intMode && opCode == `OP_UNSIGNED_MULTIPLY
    ##1 !opValid |=> $stable(product_r))
    else $error("fixed unsigned multiply changed product");
endmodule // dsp_alu_checker

bind dsp_arithmetic_logic_unit dsp_alu_checker u_chk (.clk(clk), .rst(rst), .opValid(opValid),
  .opCode(opCode), .opSecondGroup(opSecondGroup), .accSelD(accSelD), .intMode(intMode),
  .xferKind(xferKind), .ctrlConcurrent(ctrlConcurrent), .loadAcc(loadAcc), .accC_r(accC_r),
  .accD_r(accD_r), .product_r(product_r), .busy_r(busy_r), .opAccepted_r(opAccepted_r),
  .comboError_r(comboError_r));

`default_nettype wire

// ==== tb/issue_sequencer.sv ====
// Purpose: instruction sequencer model that issues ALU operations
// Assumes: fields change on the falling edge, sampled on the rising edge
// Notes: a control instruction always rides along with each operation
`timescale 1ns/1ps
`default_nettype none

module issue_sequencer
(
  // Clock
  input wire logic clk,
  // Instruction fields
  output logic opValid,
  output logic [5:0] opCode,
  output logic opSecondGroup,
  output logic accSelD,
  output logic intMode,
  output logic [1:0] xferKind,
  output logic ctrlConcurrent
);
  // Idle instruction word until the bench asks for an operation
  initial
  begin
    opValid = 1'b0;
    opCode = 6'h00;
    opSecondGroup = 1'b0;
    accSelD = 1'b0;
    intMode = 1'b0;
    xferKind = 2'h0;
    ctrlConcurrent = 1'b0;
  end

  // Illegal group pairings are only sent when a scenario commands them
  task automatic issue(input logic [5:0] op, input logic im, sel, grp,
                       input logic [1:0] xk, input int len);
    @(negedge clk);
    opValid = 1'b1;
    opCode = op;
    intMode = im;
    accSelD = sel;
    opSecondGroup = grp;
    xferKind = xk;
    ctrlConcurrent = 1'b1;
    // Held for len edges; a length of 2 overlaps a float second cycle
    repeat (len) @(negedge clk);
    opValid = 1'b0;
  endtask
endmodule // issue_sequencer

`default_nettype wire

// ==== tb/test_dsp_arithmetic_logic_unit.sv ====
// Purpose: self-checking bench for the arithmetic/logic datapath
// Assumes: inputs change on the falling edge
// Notes: integer accumulator results are judged on their low 24 bits only
`timescale 1ns/1ps
`default_nettype none
`include "dsp_alu_regs.vh"
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin numErrors++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end

module test_dsp_arithmetic_logic_unit;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic loadA, loadB, loadAcc, loadAccD;
  logic [31:0] dataA, dataB, dataAcc;
  wire opValid, opSecondGroup, accSelD, intMode, ctrlConcurrent;
  wire [5:0] opCode;
  wire [1:0] xferKind;
  wire [31:0] accC_r, accD_r, regA_r, regB_r;
  wire [47:0] product_r;
  wire carry_r, zero_r, negative_r, busy_r, opAccepted_r, comboError_r;
  int numErrors = 0;
  int nTests = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // Clock, partner and design
  // ----------------------------------------------------------------
  always #5 clk = ~clk;

  issue_sequencer u_seq (.clk(clk), .opValid(opValid), .opCode(opCode),
    .opSecondGroup(opSecondGroup), .accSelD(accSelD), .intMode(intMode),
    .xferKind(xferKind), .ctrlConcurrent(ctrlConcurrent));

  dsp_arithmetic_logic_unit u_dut (.clk(clk), .rst(rst), .opValid(opValid), .opCode(opCode),
    .opSecondGroup(opSecondGroup), .accSelD(accSelD), .intMode(intMode), .xferKind(xferKind),
    .ctrlConcurrent(ctrlConcurrent), .loadA(loadA), .dataA(dataA), .loadB(loadB),
    .dataB(dataB), .loadAcc(loadAcc), .loadAccD(loadAccD), .dataAcc(dataAcc),
    .accC_r(accC_r), .accD_r(accD_r), .regA_r(regA_r), .regB_r(regB_r),
    .product_r(product_r), .carry_r(carry_r), .zero_r(zero_r), .negative_r(negative_r),
    .busy_r(busy_r), .opAccepted_r(opAccepted_r), .comboError_r(comboError_r));

  // Load A, B and one accumulator in a single transfer cycle
  task automatic xfer(input logic [31:0] a, b, c, input logic d);
    @(negedge clk);
    {loadA, loadB, loadAcc, loadAccD} = {3'b111, d};
    dataA = a;
    dataB = b;
    dataAcc = c;
    @(negedge clk);
    {loadA, loadB, loadAcc} = 3'b000;
  endtask

  // Plain first-group op on accumulator C with no transfer
  task automatic op(input logic [5:0] c, input logic im);
    u_seq.issue(c, im, 1'b0, 1'b0, `XFER_NONE, 1);
  endtask

  task automatic endSim;
    if (numErrors == 0 && nTests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic logicOps;
    logic [5:0] codes [4] = '{`OP_ADD, `OP_AND, `OP_OR, `OP_XOR};
    logic [31:0] a = 32'hF0F0_1234;
    logic [31:0] c = 32'h0FF0_00FF;
    logic [31:0] e;
    for (int i = 0; i < 4; i++)
    begin
      xfer(a, 32'h0, c, 1'b1);
      u_seq.issue(codes[i], 1'b0, 1'b1, 1'b0, `XFER_NONE, 1);
      e = (i == 0) ? a + c : (i == 1) ? (a & c) : (i == 2) ? (a | c) : (a ^ c);
      `CHK(accD_r, e)
      `CHK(accC_r, 32'h0)
    end
  endtask

  // Product output lags the op by two edges, hence the extra wait
  task automatic mulOps;
    xfer(32'h00FF_FFFE, 32'h3, 32'h0, 1'b0);
    `CHK(regA_r, 32'h00FF_FFFE)
    `CHK(regB_r, 32'h0000_0003)
    op(`OP_SIGNED_MULTIPLY, 1'b1);
    @(negedge clk);
    `CHK(product_r, 48'hFFFF_FFFF_FFFA)
    op(`OP_UNSIGNED_MULTIPLY, 1'b1);
    @(negedge clk);
    `CHK(product_r, 48'h0000_02FF_FFFA)
    op(`OP_UNSIGNED_MULTIPLY, 1'b0);
    @(negedge clk);
    `CHK(product_r, 48'h0000_02FF_FFFA)
    op(`OP_SIGNED_MULTIPLY, 1'b0);
    @(negedge clk);
    `CHK(product_r, 48'hFFFF_FFFF_FFFA)
  endtask

  // Leaves the carry set for the later carry-chained ops
  task automatic carryOps;
    xfer(32'h00FF_FFFF, 32'h0, 32'h1, 1'b0);
    op(`OP_ADD, 1'b1);
    `CHK(accC_r[23:0], 24'h000000)
    `CHK(carry_r, 1'b1)
    op(`OP_ADD_WITH_CARRY, 1'b1);
    `CHK(accC_r[23:0], 24'h000000)
    xfer(32'h00FF_FFFF, 32'h0, 32'h5, 1'b0);
    op(`OP_ADD_WITH_CARRY, 1'b0);
    `CHK(accC_r, 32'h5)
    op(`OP_SUB, 1'b1);
    `CHK(accC_r[23:0], 24'h000006)
    `CHK(carry_r, 1'b1)
    op(`OP_SUBTRACT_WITH_BORROW, 1'b1);
    `CHK(accC_r[23:0], 24'h000006)
    `CHK(carry_r, 1'b1)
  endtask

  // Product of -3 and 4 gives low half -12 and high half -1
  task automatic prodOps;
    xfer(32'h00FF_FFFD, 32'h4, 32'h64, 1'b0);
    op(`OP_SIGNED_MULTIPLY, 1'b1);
    op(`OP_MULTIPLY_ACCUMULATE, 1'b1);
    `CHK(accC_r[23:0], 24'h000058)
    op(`OP_MULTIPLY_SUBTRACT, 1'b1);
    `CHK(accC_r[23:0], 24'h000064)
    op(`OP_MOVE_PRODUCT_AND_MULTIPLY, 1'b1);
    `CHK(accC_r[23:0], 24'hFFFFF4)
    op(`OP_ADD_PRODUCT_HIGH, 1'b1);
    `CHK(accC_r[23:0], 24'hFFFFF3)
    op(`OP_ADD_PRODUCT_LOW_CARRY, 1'b1);
    `CHK(accC_r[23:0], 24'hFFFFE8)
    op(`OP_ADD_PRODUCT_LOW, 1'b0);
    `CHK(accC_r[23:0], 24'hFFFFE8)
  endtask

  task automatic negOps;
    xfer(32'h5, 32'h0, 32'h5, 1'b0);
    op(`OP_COMPARE_ACCUMULATOR, 1'b1);
    `CHK(accC_r[23:0], 24'h000005)
    `CHK(zero_r, 1'b1)
    op(`OP_NEGATE_WITH_CARRY, 1'b1);
    `CHK(accC_r[23:0], 24'hFFFFFA)
    op(`OP_ABSOLUTE_ACCUMULATOR, 1'b1);
    `CHK(accC_r[23:0], 24'h000006)
    op(`OP_NEGATE_ACCUMULATOR, 1'b1);
    `CHK(accC_r[23:0], 24'hFFFFFA)
    `CHK(negative_r, 1'b1)
    op(`OP_NEGATE_WITH_CARRY, 1'b0);
    `CHK(accC_r[23:0], 24'hFFFFFA)
  endtask

  // The first float add is held over its second cycle, which must be ignored
  task automatic floatOps;
    xfer(32'h7, 32'h0, 32'hA, 1'b0);
    u_seq.issue(`OP_FLOAT_ADD, 1'b0, 1'b0, 1'b0, `XFER_NONE, 2);
    `CHK(accC_r, 32'h11)
    `CHK(busy_r, 1'b0)
    op(`OP_FLOAT_ADD, 1'b1);
    `CHK(busy_r, 1'b1)
    `CHK(accC_r, 32'h11)
    @(negedge clk);
    `CHK(accC_r, 32'h18)
    op(`OP_FLOAT_SUBTRACT, 1'b0);
    `CHK(accC_r, 32'h18)
    @(negedge clk);
    `CHK(accC_r, 32'h11)
  endtask

  task automatic comboOps;
    xfer(32'h2, 32'h0, 32'h1, 1'b0);
    u_seq.issue(`OP_ADD, 1'b0, 1'b0, 1'b1, `XFER_TRIPLE, 1);
    `CHK(comboError_r, 1'b1)
    `CHK(accC_r, 32'h1)
    u_seq.issue(`OP_ADD, 1'b0, 1'b0, 1'b1, `XFER_DOUBLE, 1);
    `CHK(accC_r, 32'h3)
    u_seq.issue(`OP_ADD, 1'b0, 1'b0, 1'b0, `XFER_TRIPLE, 1);
    `CHK(accC_r, 32'h5)
    `CHK(opAccepted_r, 1'b1)
    u_seq.issue(`OP_FLOAT_ADD, 1'b0, 1'b0, 1'b1, `XFER_DOUBLE, 1);
    `CHK(comboError_r, 1'b1)
    `CHK(busy_r, 1'b0)
    `CHK(accC_r, 32'h5)
  endtask

  // Main sequence
  initial
  begin
    {loadA, loadB, loadAcc, loadAccD} = 4'h0;
    dataA = 32'h0;
    dataB = 32'h0;
    dataAcc = 32'h0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    logicOps();
    mulOps();
    carryOps();
    prodOps();
    negOps();
    floatOps();
    comboOps();
    endSim();
  end

  // Hang guard: the whole run needs under a hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      numErrors++;
      endSim();
    end
  end
endmodule // test_dsp_arithmetic_logic_unit

`default_nettype wire
